// file: design/iafc_regs.sv
// Purpose: input alarm status and per-input frequency configuration registers
// Assumes: register port decoded from the serial configuration interface
// Notes: straps sampled while reset is held
`timescale 1ns/1ps

// Overview of operation
// R1: alarm status read-only except in test mode; resets to both alarms set.
// R2: status bit 5 shows second input no-activity alarm.
// R3: status bit 1 shows first input no-activity alarm.
// R4: outside test mode, alarm bits follow the activity monitor outputs through the two-flop pin synchroniser.
// R5: first config register resets upper nibble zero, lower nibble from straps.
// R6: config bit 7 routes input through programmable pre-divider.
// R7: config bit 6 passes input through preset pre-divider for 8 kHz lock.
// R8: second config register at 0x23 acts identically for second input, except that it resets to 0x00 instead of from straps.
// R9: unused status bits read zero and ignore writes.
module iafc_regs
	import iafc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// pins
	input wire logic test_mode,
	input wire logic first_no_activity,
	input wire logic second_no_activity,
	input wire logic [2:0] input_freq_strap_pins,
	input wire logic network_standard_strap,
	// configuration outputs
	output logic first_predivider_route_select_q,
	output logic first_lock_to_8k_select_q,
	output logic [3:0] first_input_freq_code_q,
	output logic second_predivider_route_select_q,
	output logic second_lock_to_8k_select_q,
	output logic [3:0] second_input_freq_code_q,
	output logic network_standard_q
);

	// =========================================================
	// state
	typedef struct packed {
		logic [7:0] alarm_status;
		logic [1:0][7:0] cfg;
		logic [7:0] rdata;
		logic rvalid;
		logic netstd;
	} iafc_state_type;

	iafc_state_type state_q;
	iafc_state_type state_d;

	// =========================================================
	// pin synchronisers
	logic [6:0] pins_s;

	iafc_sync #(.WIDTH(7)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({test_mode, second_no_activity, first_no_activity,
			network_standard_strap, input_freq_strap_pins}),
		.sync_out(pins_s)
	);

	// =========================================================
	// strap decode
	function automatic logic [3:0] iafc_strap_code(input logic [2:0] strap);
		iafc_strap_code = {1'b0, strap};
	endfunction

	// =========================================================
	// next state
	always_comb begin
		state_d = state_q;
		state_d.rvalid = 1'b0;
		if (pins_s[6]) begin
			if (reg_wr_en && reg_addr == IAFC_ALARM_STATUS_OFS) begin
				state_d.alarm_status = reg_wdata & IAFC_ALARM_MASK; // [R1] [R9]
			end
		end else begin
			state_d.alarm_status = 8'h00; // [R9]
			state_d.alarm_status[IAFC_SECOND_ALARM_BIT] = pins_s[5]; // [R2] [R4]
			state_d.alarm_status[IAFC_FIRST_ALARM_BIT] = pins_s[4]; // [R3] [R4]
		end
		if (reg_wr_en && reg_addr == IAFC_FIRST_CFG_OFS) begin
			state_d.cfg[0] = reg_wdata;
		end
		if (reg_wr_en && reg_addr == IAFC_SECOND_CFG_OFS) begin
			state_d.cfg[1] = reg_wdata; // [R8]
		end
		if (reg_rd_en) begin
			state_d.rvalid = 1'b1;
			unique case (reg_addr)
				IAFC_ALARM_STATUS_OFS: state_d.rdata = state_q.alarm_status;
				IAFC_FIRST_CFG_OFS: state_d.rdata = state_q.cfg[0];
				IAFC_SECOND_CFG_OFS: state_d.rdata = state_q.cfg[1];
				default: state_d.rdata = 8'h00;
			endcase
		end
		if (sys_rst) begin
			state_d.alarm_status = IAFC_ALARM_STATUS_RST; // [R1]
			state_d.cfg[0] = {IAFC_CFG_UPPER_RST, iafc_strap_code(pins_s[2:0])}; // [R5]
			state_d.cfg[1] = IAFC_SECOND_CFG_RST;
			state_d.rdata = 8'h00;
			state_d.rvalid = 1'b0;
			state_d.netstd = pins_s[3];
		end
	end

	always_ff @(posedge core_clk) begin
		state_q <= state_d;
	end

	// =========================================================
	// outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
			first_predivider_route_select_q <= 1'b0;
			first_lock_to_8k_select_q <= 1'b0;
			first_input_freq_code_q <= 4'h0;
			second_predivider_route_select_q <= 1'b0;
			second_lock_to_8k_select_q <= 1'b0;
			second_input_freq_code_q <= 4'h0;
			network_standard_q <= 1'b0;
		end else begin
			reg_rdata_q <= state_d.rdata;
			reg_rvalid_q <= state_d.rvalid;
			first_predivider_route_select_q <= state_d.cfg[0][IAFC_ROUTE_BIT]; // [R6]
			first_lock_to_8k_select_q <= state_d.cfg[0][IAFC_LOCK8K_BIT]; // [R7]
			first_input_freq_code_q <= state_d.cfg[0][IAFC_CODE_MSB:0];
			second_predivider_route_select_q <= state_d.cfg[1][IAFC_ROUTE_BIT]; // [R6] [R8]
			second_lock_to_8k_select_q <= state_d.cfg[1][IAFC_LOCK8K_BIT]; // [R7] [R8]
			second_input_freq_code_q <= state_d.cfg[1][IAFC_CODE_MSB:0];
			network_standard_q <= state_d.netstd;
		end
	end

endmodule

// file: design/iafc_pkg.sv
// Purpose: constants for the input alarm and frequency configuration registers
// Assumes: 8-bit register port, byte offsets as printed
// Notes: imported by iafc_regs; iafc_sync does not use it
package iafc_pkg;

	// =========================================================
	// register offsets
	localparam logic [7:0] IAFC_ALARM_STATUS_OFS = 8'h11;
	localparam logic [7:0] IAFC_FIRST_CFG_OFS = 8'h22;
	localparam logic [7:0] IAFC_SECOND_CFG_OFS = 8'h23;

	// =========================================================
	// field positions
	localparam int IAFC_SECOND_ALARM_BIT = 5;
	localparam int IAFC_FIRST_ALARM_BIT = 1;
	localparam int IAFC_ROUTE_BIT = 7;
	localparam int IAFC_LOCK8K_BIT = 6;
	localparam int IAFC_CODE_MSB = 3;

	// =========================================================
	// reset values and alarm write mask
	localparam logic [7:0] IAFC_ALARM_STATUS_RST = 8'h22;
	localparam logic [3:0] IAFC_CFG_UPPER_RST = 4'h0;
	localparam logic [7:0] IAFC_SECOND_CFG_RST = 8'h00;
	localparam logic [7:0] IAFC_ALARM_MASK = 8'h22;

endpackage

// file: design/iafc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock core_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module iafc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// =========================================================
	// two stages, never cleared so straps reach the logic while reset is held
	logic [WIDTH-1:0] meta_q;
	logic rst_seen_q;

	always_ff @(posedge core_clk) begin
		meta_q <= async_in;
		sync_out <= meta_q;
		rst_seen_q <= sys_rst;
	end

endmodule

// file: dv/iafc_mon.sv
// Purpose: activity monitor model
// Assumes: one clock
// Notes: alarm follows lost one edge later
`timescale 1ns/1ps
module iafc_mon (
	input wire logic core_clk,
	input wire logic [1:0] lost,
	output logic [1:0] alarm
);
	always_ff @(posedge core_clk) alarm <= lost;
endmodule

// file: dv/iafc_regs_sva.sv
// Purpose: port checks for iafc_regs
// Assumes: straps fixed
// Notes: bound below
`timescale 1ns/1ps
module iafc_regs_sva (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire logic test_mode,
	input wire logic first_no_activity,
	input wire logic second_no_activity,
	input wire logic [2:0] input_freq_strap_pins,
	input wire logic first_predivider_route_select_q,
	input wire logic first_lock_to_8k_select_q,
	input wire logic [3:0] first_input_freq_code_q,
	input wire logic [3:0] second_input_freq_code_q,
	input wire logic network_standard_strap,
	input wire logic second_predivider_route_select_q,
	input wire logic second_lock_to_8k_select_q,
	input wire logic network_standard_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_RST: assert property ($fell(sys_rst) && reg_rd_en && reg_addr == 8'h11
		|=> reg_rdata_q == 8'h22) else $error("status reset");
	AST_SECOND_REFERENCE_INPUT: assert property ((!test_mode && $stable(second_no_activity))[*6]
		##0 reg_rd_en && reg_addr == 8'h11 |=> reg_rdata_q[5] == $past(second_no_activity))
		else $error("alarm two");
	AST_FIRST_REFERENCE_INPUT: assert property ((!test_mode && $stable(first_no_activity))[*6]
		##0 reg_rd_en && reg_addr == 8'h11 |=> reg_rdata_q[1] == $past(first_no_activity))
		else $error("alarm one");
	AST_RV: assert property (reg_rd_en |=> reg_rvalid_q) else $error("rvalid");
	AST_CFGRST: assert property ($fell(sys_rst) |=>
		first_input_freq_code_q == {1'b0, input_freq_strap_pins}) else $error("code reset");
	AST_CFG1: assert property (reg_wr_en && reg_addr == 8'h22 |=>
		{first_predivider_route_select_q, first_lock_to_8k_select_q} == $past(reg_wdata[7:6]))
		else $error("cfg one");
	AST_CFG2: assert property (reg_wr_en && reg_addr == 8'h23 |=>
		second_input_freq_code_q == $past(reg_wdata[3:0])) else $error("cfg two");
	AST_UNUSED: assert property (reg_rd_en && reg_addr == 8'h11 |=>
		(reg_rdata_q & 8'hDD) == 8'h00) else $error("unused bits");
	AST_NETSTD: assert property ($fell(sys_rst) |=>
		network_standard_q == network_standard_strap) else $error("netstd reset");
	AST_CFG1C: assert property (reg_wr_en && reg_addr == 8'h22 |=>
		first_input_freq_code_q == $past(reg_wdata[3:0])) else $error("code one");
	AST_CFG2RT: assert property (reg_wr_en && reg_addr == 8'h23 |=>
		{second_predivider_route_select_q, second_lock_to_8k_select_q} == $past(reg_wdata[7:6]))
		else $error("cfg two route");
endmodule
bind iafc_regs iafc_regs_sva i_sva (.*);

// file: dv/input_activity_alarm_and_freq_cfg_tb.sv
// Purpose: self-checking bench for iafc_regs
// Assumes: 40 MHz clock
// Notes: reads scored through a queue
`timescale 1ns/1ps
module input_activity_alarm_and_freq_cfg_tb;
	logic core_clk = 0, sys_rst = 1, reg_wr_en = 0, reg_rd_en = 0, test_mode = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, exp_q[$];
	logic [1:0] lost = 2'b11, alarm;
	logic reg_rvalid_q;
	logic [31:0] seed = 32'hA25CBE44;
	int num_errors = 0, total_checks = 0, cyc = 0;
	iafc_mon i_mon (.core_clk(core_clk), .lost(lost), .alarm(alarm));
	iafc_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .test_mode(test_mode),
		.first_no_activity(alarm[0]), .second_no_activity(alarm[1]),
		.input_freq_strap_pins(3'h5), .network_standard_strap(1'b1),
		.first_predivider_route_select_q(), .first_lock_to_8k_select_q(),
		.first_input_freq_code_q(), .second_predivider_route_select_q(),
		.second_lock_to_8k_select_q(), .second_input_freq_code_q(), .network_standard_q());
	initial forever #12.5 core_clk = ~core_clk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_wr_en = w;
		reg_rd_en = !w;
		reg_addr = a;
		reg_wdata = d;
		if (!w) exp_q.push_back(d);
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got);
		total_checks++;
		if (exp_q.size() == 0 || got !== exp_q.pop_front()) begin
			num_errors++;
			$display("mismatch at %0t: read data %h", $time, got);
		end
	endtask
	always @(negedge core_clk) if (reg_rvalid_q === 1'b1) chk(reg_rdata_q);
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 1000) begin
			num_errors++;
			stop_test();
		end
	end
	// ====
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		sys_rst = 0;
		op(0, 8'h11, 8'h22);
		op(0, 8'h22, 8'h05);
		op(0, 8'h23, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lost = i[1:0];
			op(1, 8'h11, 8'hFF);
			repeat (7) op(1, 8'h40, 8'hFF);
			op(0, 8'h11, {2'h0, i[1], 3'h0, i[0], 1'b0});
		end
		lost = 2'b00;
		test_mode = 1;
		repeat (7) op(1, 8'h40, 8'h00);
		op(1, 8'h11, 8'hFF);
		op(0, 8'h11, 8'h22);
		test_mode = 0;
		for (int k = 0; k < 6; k++) begin
			seed = nx(seed);
			op(1, 8'h22, seed[7:0]);
			op(0, 8'h22, seed[7:0]);
			op(1, 8'h23, seed[15:8]);
			op(0, 8'h23, seed[15:8]);
		end
		op(0, 8'h40, 8'h00);
		reg_rd_en = 0;
		repeat (3) @(posedge core_clk);
		stop_test();
	end
endmodule
